/* ppc_pkg.sv */
// Purpose: Shared constants and types for the port policy and interrupt
//          control register group.
// Assumes: Eight-bit registers reached through an internal register port.
// Notes:   Reset values that come from straps are loaded after release.
package ppc_pkg;

    // Register offsets on the management register port.
    localparam logic [7:0] OFS_FOLDBACK_THRESHOLD_SELECT = 8'h0b;
    localparam logic [7:0] OFS_CLASSIFICATION_EXTENSION_ENABLE = 8'h0c;
    localparam logic [7:0] OFS_POWER_SHED_PRIORITY = 8'h0d;
    localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h0e;

    // Field positions.
    localparam int POS_FOLDBACK_LEVEL_SELECT = 0;
    localparam int POS_HIGH_CLASS_ENABLE = 4;
    localparam int POS_DOUBLE_CLASS_ENABLE = 0;
    localparam int POS_IRQ_PIN_CLEAR = 2;
    localparam int POS_IRQ_SOURCE_CLEAR = 1;
    localparam int POS_IRQ_GLOBAL_ENABLE = 0;

    // Values after reset.
    localparam logic RST_FOLDBACK_LEVEL_SELECT = 1'b1;
    localparam logic [7:0] RST_POWER_SHED_PRIORITY = 8'he4;
    localparam logic RST_IRQ_GLOBAL_ENABLE = 1'b1;

    // Cycles after reset release before strap levels are trusted.
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

    // Classification codes that allow a second classification event.
    localparam logic [2:0] CLASS_CODE_4 = 3'h4;
    localparam logic [2:0] CLASS_CODE_5 = 3'h5;

    // Register port request carrier.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ppc_req_t;

endpackage

/* ppc_shed_pick.sv */
// Purpose: Picks the one powered port to shed on a power limit trip.
// Assumes: Higher rank code sheds first; ties go to the higher port.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module ppc_shed_pick #(
    parameter int NUM_PORTS = 4
) (
    // Per-port rank codes and candidacy.
    input wire logic [NUM_PORTS-1:0][1:0] rank_in,
    input wire logic [NUM_PORTS-1:0] cand_in,
    // One-hot choice, zero when no candidate exists.
    output logic [NUM_PORTS-1:0] pick_out
);

    // A pick module with no ports cannot choose anything.
    if (NUM_PORTS < 1) begin : g_chk
        $error("ppc_shed_pick needs at least one port");
    end

    // Scan upward; using >= lets a later equal rank take the choice.
    always_comb begin
        logic [1:0] best;
        logic found;
        best = 2'h0;
        found = 1'b0;
        pick_out = '0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (cand_in[i] && (!found || rank_in[i] >= best)) begin
                pick_out = '0;
                pick_out[i] = 1'b1;
                best = rank_in[i];
                found = 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

/* ppc_port_policy.sv */
// Purpose: Port policy and interrupt control registers of a quad PSE.
// Assumes: Register port and event inputs share CLK_IN; straps are async.
// Notes:   Strap-derived bits settle a few cycles after reset release.
`timescale 1ns/1ps
`default_nettype none
module ppc_port_policy
    import ppc_pkg::*;
#(
    parameter int NUM_PORTS = 4
) (
    // Clock and reset.
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    // Register port from the management bus decoder.
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    output logic [7:0] REG_RDATA_OUT,
    // Strap pins, asynchronous.
    input wire logic HIGH_CLASS_STRAP_PIN_IN,
    input wire logic AUTO_STRAP_PIN_IN,
    // Interrupt events from the event registers, one-cycle pulses.
    input wire logic IRQ_EVENT_A_IN,
    input wire logic IRQ_EVENT_B_IN,
    // Interrupt pins and event register wipe.
    output logic IRQ_OUT_A_OUT,
    output logic IRQ_OUT_B_OUT,
    output logic EVENT_CLEAR_OUT,
    // Power limit supervision.
    input wire logic TOTAL_POWER_LIMIT_ENABLE_IN,
    input wire logic TOTAL_POWER_LIMIT_TRIP_IN,
    input wire logic [NUM_PORTS-1:0] PORT_POWERED_IN,
    output logic [NUM_PORTS-1:0] SHED_PORT_OUT,
    // Classification.
    input wire logic [NUM_PORTS-1:0] CLASS_DONE_IN,
    input wire logic [NUM_PORTS-1:0][2:0] FIRST_CLASS_IN,
    output logic [NUM_PORTS-1:0] SECOND_CLASS_REQ_OUT,
    // Configuration levels for the port engines.
    output logic FOLDBACK_LEVEL_SELECT_OUT,
    output logic [NUM_PORTS-1:0] HIGH_CLASS_ENABLE_OUT,
    output logic [NUM_PORTS-1:0] DOUBLE_CLASS_ENABLE_OUT
);

    // The register layout packs four ports per byte and cannot grow.
    if (NUM_PORTS != 4) begin : g_chk
        $error("ppc_port_policy supports exactly four ports");
    end

    // Whole state of the block.
    typedef struct packed {
        logic hc_s1;          // Class strap, first sync stage.
        logic hc_s2;          // Class strap, second sync stage.
        logic au_s1;          // Auto strap, first sync stage.
        logic au_s2;          // Auto strap, second sync stage.
        logic [1:0] settle;   // Cycles since reset release.
        logic loaded;         // Strap values have been taken.
        logic fold_sel;       // Foldback threshold select.
        logic [3:0] hc_en;    // High class enables.
        logic [3:0] dc_en;    // Double class enables.
        logic [7:0] rank;     // Shed ranks, two bits per port.
        logic irq_en;         // Global interrupt enable.
        logic pin_clr;        // Pin clear command, self-clearing.
        logic src_clr;        // Source clear command, self-clearing.
        logic irq_a;          // Pending state behind pin A.
        logic irq_b;          // Pending state behind pin B.
        logic [7:0] rdata;    // Read data register.
        logic [3:0] shed;     // Shed request pulse.
        logic [3:0] second;   // Second class request pulse.
    } ppc_state_t;

    ppc_state_t state_reg;
    ppc_state_t state_next;
    ppc_req_t req;             // Bundled register request.
    logic [3:0] pick;          // Port chosen for shedding.

    assign req = '{wr: REG_WR_IN, rd: REG_RD_IN, addr: REG_ADDR_IN,
                   wdata: REG_WDATA_IN};

    // Chooses among powered ports; gating by trip happens below.
    ppc_shed_pick #(
        .NUM_PORTS(4)
    ) u_pick (
        .rank_in(state_reg.rank),
        .cand_in(PORT_POWERED_IN),
        .pick_out(pick)
    );

    // Next-state logic for every register of the block.
    always_comb begin
        state_next = state_reg;
        // Strap synchronisers; stage one feeds stage two only.
        state_next.hc_s1 = HIGH_CLASS_STRAP_PIN_IN;
        state_next.hc_s2 = state_reg.hc_s1;
        state_next.au_s1 = AUTO_STRAP_PIN_IN;
        state_next.au_s2 = state_reg.au_s1;
        // Wait for the synchronisers to fill before loading straps.
        if (!state_reg.loaded) begin
            if (state_reg.settle == STRAP_SETTLE_CYCLES) begin
                state_next.loaded = 1'b1;
                state_next.hc_en = {4{state_reg.hc_s2}};
                state_next.dc_en = {4{state_reg.au_s2}};
            end else begin
                state_next.settle = state_reg.settle + 2'h1;
            end
        end
        // Commands act one cycle after they are written, then drop.
        state_next.pin_clr = 1'b0;
        state_next.src_clr = 1'b0;
        if (state_reg.pin_clr || state_reg.src_clr) begin
            state_next.irq_a = 1'b0;
            state_next.irq_b = 1'b0;
        end
        // A new event beats a clear in the same cycle, whatever the enable.
        if (IRQ_EVENT_A_IN) begin
            state_next.irq_a = 1'b1;
        end
        if (IRQ_EVENT_B_IN) begin
            state_next.irq_b = 1'b1;
        end
        // Register writes; reserved positions are simply not stored.
        if (req.wr) begin
            unique case (req.addr)
                OFS_FOLDBACK_THRESHOLD_SELECT: begin
                    state_next.fold_sel =
                        req.wdata[POS_FOLDBACK_LEVEL_SELECT];
                end
                OFS_CLASSIFICATION_EXTENSION_ENABLE: begin
                    state_next.hc_en =
                        req.wdata[POS_HIGH_CLASS_ENABLE +: 4];
                    state_next.dc_en =
                        req.wdata[POS_DOUBLE_CLASS_ENABLE +: 4];
                end
                OFS_POWER_SHED_PRIORITY: begin
                    state_next.rank = req.wdata;
                end
                OFS_INTERRUPT_CONTROL: begin
                    state_next.irq_en = req.wdata[POS_IRQ_GLOBAL_ENABLE];
                    state_next.pin_clr = req.wdata[POS_IRQ_PIN_CLEAR];
                    state_next.src_clr = req.wdata[POS_IRQ_SOURCE_CLEAR];
                end
                default: begin
                    // Other offsets belong to other register groups.
                end
            endcase
        end
        // Read data; unmapped offsets and reserved bits read zero.
        if (req.rd) begin
            unique case (req.addr)
                OFS_FOLDBACK_THRESHOLD_SELECT: begin
                    state_next.rdata = {7'h00, state_reg.fold_sel};
                end
                OFS_CLASSIFICATION_EXTENSION_ENABLE: begin
                    state_next.rdata = {state_reg.hc_en, state_reg.dc_en};
                end
                OFS_POWER_SHED_PRIORITY: begin
                    state_next.rdata = state_reg.rank;
                end
                OFS_INTERRUPT_CONTROL: begin
                    state_next.rdata = {5'h00, state_reg.pin_clr,
                                        state_reg.src_clr,
                                        state_reg.irq_en};
                end
                default: begin
                    state_next.rdata = 8'h00;
                end
            endcase
        end
        // Shedding pulses in every cycle the trip is high, only when the limit is on.
        state_next.shed = 4'h0;
        if (TOTAL_POWER_LIMIT_TRIP_IN && TOTAL_POWER_LIMIT_ENABLE_IN) begin
            state_next.shed = pick;
        end
        // Second classification only after a class 4 or 5 first result.
        for (int i = 0; i < 4; i++) begin
            state_next.second[i] = CLASS_DONE_IN[i] && state_reg.dc_en[i] &&
                ((FIRST_CLASS_IN[i] == CLASS_CODE_4) ||
                 (FIRST_CLASS_IN[i] == CLASS_CODE_5));
        end
    end

    // State register; reset gives constants only, straps come later.
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_reg <= '0;
            state_reg.fold_sel <= RST_FOLDBACK_LEVEL_SELECT;
            state_reg.rank <= RST_POWER_SHED_PRIORITY;
            state_reg.irq_en <= RST_IRQ_GLOBAL_ENABLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs; pins are gated by the enable, the pending state is not.
    assign IRQ_OUT_A_OUT = state_reg.irq_a && state_reg.irq_en;
    assign IRQ_OUT_B_OUT = state_reg.irq_b && state_reg.irq_en;
    assign EVENT_CLEAR_OUT = state_reg.src_clr;
    assign REG_RDATA_OUT = state_reg.rdata;
    assign SHED_PORT_OUT = state_reg.shed;
    assign SECOND_CLASS_REQ_OUT = state_reg.second;
    assign FOLDBACK_LEVEL_SELECT_OUT = state_reg.fold_sel;
    assign HIGH_CLASS_ENABLE_OUT = state_reg.hc_en;
    assign DOUBLE_CLASS_ENABLE_OUT = state_reg.dc_en;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    a_fold_write: assert property (req.wr &&
        req.addr == OFS_FOLDBACK_THRESHOLD_SELECT |=>
        FOLDBACK_LEVEL_SELECT_OUT == $past(REG_WDATA_IN[0]))
        else $error("Foldback select did not take written value");
    a_high_class_write: assert property (req.wr &&
        req.addr == OFS_CLASSIFICATION_EXTENSION_ENABLE |=>
        HIGH_CLASS_ENABLE_OUT == $past(REG_WDATA_IN[7:4]))
        else $error("High class enables did not take written value");
    a_strap_load: assert property ($rose(state_reg.loaded) &&
        !$past(REG_WR_IN) |->
        HIGH_CLASS_ENABLE_OUT == {4{$past(state_reg.hc_s2)}}
        && DOUBLE_CLASS_ENABLE_OUT == {4{$past(state_reg.au_s2)}})
        else $error("Strap values not loaded into enables");
    a_second_class: assert property (SECOND_CLASS_REQ_OUT[1] |->
        $past(CLASS_DONE_IN[1]) && $past(state_reg.dc_en[1]) &&
        ($past(FIRST_CLASS_IN[1]) == CLASS_CODE_4 ||
         $past(FIRST_CLASS_IN[1]) == CLASS_CODE_5))
        else $error("Second class request without class 4 or 5");
    a_shed_onehot: assert property ($onehot0(SHED_PORT_OUT) &&
        ((SHED_PORT_OUT & ~$past(PORT_POWERED_IN)) == 4'h0))
        else $error("Shed request not one powered port");
    a_shed_gate: assert property (SHED_PORT_OUT != 4'h0 |->
        $past(TOTAL_POWER_LIMIT_TRIP_IN &&
        TOTAL_POWER_LIMIT_ENABLE_IN))
        else $error("Shed request without enabled limit trip");
    a_pin_clear: assert property (state_reg.pin_clr && !IRQ_EVENT_A_IN &&
        !(req.wr && req.addr == OFS_INTERRUPT_CONTROL) |=>
        !IRQ_OUT_A_OUT && !state_reg.pin_clr && !EVENT_CLEAR_OUT)
        else $error("Pin clear failed or touched events");
    a_source_clear: assert property (EVENT_CLEAR_OUT && !IRQ_EVENT_A_IN &&
        !IRQ_EVENT_B_IN && !(req.wr && req.addr == OFS_INTERRUPT_CONTROL)
        |=> !IRQ_OUT_A_OUT && !IRQ_OUT_B_OUT && !EVENT_CLEAR_OUT)
        else $error("Source clear did not drop pins and self-clear");
    a_irq_gate: assert property (IRQ_EVENT_B_IN |=>
        state_reg.irq_b && (IRQ_OUT_B_OUT == state_reg.irq_en))
        else $error("Interrupt pin not following event and enable");
    a_reserved_read: assert property (req.rd &&
        req.addr == OFS_INTERRUPT_CONTROL |=>
        REG_RDATA_OUT[7:3] == 5'h00)
        else $error("Reserved bits read nonzero");

endmodule
`default_nettype wire

/* ppc_host_model.sv */
// Purpose: Host side of the register port, issuing single-byte accesses.
// Assumes: The block samples requests on rising edges of clk_in.
// Notes:   Released address and data show inverted values, never old ones.
`timescale 1ns/1ps
`default_nettype none
module ppc_host_model
    import ppc_pkg::*;
(
    // Clock shared with the block.
    input wire logic clk_in,
    // Request towards the block and the read answer.
    output ppc_req_t req_out,
    input wire logic [7:0] rdata_in
);
    // Idle bus at time zero.
    initial begin
        req_out = '0;
    end

    // One write: strobe held across exactly one rising edge.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        req_out = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge clk_in);
        // Inverted leftovers so a late sample of the bus cannot match.
        req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    // One read: data is registered at the strobe edge, so take it after.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_in);
        req_out = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge clk_in);
        data = rdata_in;
        req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
    endtask
endmodule
`default_nettype wire

/* ppc_port_policy_tb_top.sv */
// Purpose: Self-checking bench for the port policy register group.
// Assumes: Inputs change on falling edges; the host model owns the bus.
// Notes:   A second reset swaps the strap levels to cover both loads.
`timescale 1ns/1ps
`default_nettype none
module ppc_port_policy_tb_top;
    import ppc_pkg::*;
    // Clock, reset and strap levels.
    logic clk, nrst, hc_strap, au_strap;
    // Event, power limit and classification stimulus.
    logic ev_a, ev_b, pl_en, pl_trip;
    logic [3:0] powered, done, shed, sc_req, hc_en, dc_en, want;
    logic [3:0][2:0] first_cls;
    // Read data, pins and their packed view.
    logic [7:0] rdata, pins;
    logic irq_a, irq_b, ev_clr, fold;
    ppc_req_t req;
    int mismatches, checks_done, cycles;
    assign pins = {5'h0, ev_clr, irq_b, irq_a};

    ppc_host_model i_ppc_host_model (.clk_in(clk), .req_out(req),
        .rdata_in(rdata));

    ppc_port_policy #(.NUM_PORTS(4)) i_ppc_port_policy (
        .CLK_IN(clk), .NRST_IN(nrst),
        .REG_WR_IN(req.wr), .REG_RD_IN(req.rd), .REG_ADDR_IN(req.addr),
        .REG_WDATA_IN(req.wdata), .REG_RDATA_OUT(rdata),
        .HIGH_CLASS_STRAP_PIN_IN(hc_strap), .AUTO_STRAP_PIN_IN(au_strap),
        .IRQ_EVENT_A_IN(ev_a), .IRQ_EVENT_B_IN(ev_b),
        .IRQ_OUT_A_OUT(irq_a), .IRQ_OUT_B_OUT(irq_b),
        .EVENT_CLEAR_OUT(ev_clr),
        .TOTAL_POWER_LIMIT_ENABLE_IN(pl_en),
        .TOTAL_POWER_LIMIT_TRIP_IN(pl_trip),
        .PORT_POWERED_IN(powered), .SHED_PORT_OUT(shed),
        .CLASS_DONE_IN(done), .FIRST_CLASS_IN(first_cls),
        .SECOND_CLASS_REQ_OUT(sc_req), .FOLDBACK_LEVEL_SELECT_OUT(fold),
        .HIGH_CLASS_ENABLE_OUT(hc_en), .DOUBLE_CLASS_ENABLE_OUT(dc_en));

    // 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // The run needs under two hundred cycles; the ceiling leaves wide margin.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // Compares one value and counts the outcome.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen,
                exp);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        i_ppc_host_model.write_reg(addr, data);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] val;
        i_ppc_host_model.read_reg(addr, val);
        check(val, exp);
    endtask

    // Strap enables settle three edges after release, so wait four.
    task automatic do_reset(input logic hc, input logic au);
        @(negedge clk);
        nrst = 1'b0;
        hc_strap = hc;
        au_strap = au;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    // One-cycle event pulse on line a or b.
    task automatic event_pulse(input logic on_b);
        @(negedge clk);
        ev_a = ~on_b;
        ev_b = on_b;
        @(negedge clk);
        ev_a = 1'b0;
        ev_b = 1'b0;
    endtask

    // Loads ranks, sets the powered ports, trips once, checks the pick.
    task automatic shed_case(input logic [7:0] rank, input logic [3:0] pw,
        input logic en, input logic [3:0] exp);
        wr(8'h0d, rank);
        powered = pw;
        pl_en = en;
        @(negedge clk);
        pl_trip = 1'b1;
        @(negedge clk);
        pl_trip = 1'b0;
        check({4'h0, shed}, {4'h0, exp});
    endtask

    initial begin
        {nrst, ev_a, ev_b, pl_en, pl_trip, hc_strap, au_strap} = '0;
        {powered, done, first_cls, cycles} = '0;
        {mismatches, checks_done} = '0;
        do_reset(1'b1, 1'b0);
        rd_chk(8'h0b, 8'h01);
        rd_chk(8'h0c, 8'hf0);
        rd_chk(8'h0d, 8'he4);
        rd_chk(8'h0e, 8'h01);
        check({3'h0, fold, hc_en}, 8'h1f);
        check({4'h0, dc_en}, 8'h00);
        $display("test reset_values done");
        // Reserved bits and unmapped offsets must read back as zero.
        wr(8'h0b, 8'hfe);
        rd_chk(8'h0b, 8'h00);
        check({7'h0, fold}, 8'h00);
        wr(8'h0b, 8'hff);
        rd_chk(8'h0b, 8'h01);
        wr(8'h0e, 8'hf9);
        rd_chk(8'h0e, 8'h01);
        wr(8'h0a, 8'hff);
        rd_chk(8'h0a, 8'h00);
        rd_chk(8'h0f, 8'h00);
        wr(8'h0c, 8'h5a);
        rd_chk(8'h0c, 8'h5a);
        check({hc_en, dc_en}, 8'h5a);
        $display("test access done");
        // Double class is enabled on ports 2 and 4 only; codes 3 to 6.
        for (int p = 0; p < 4; p++) begin
            for (int c = 3; c < 7; c++) begin
                @(negedge clk);
                done[p] = 1'b1;
                first_cls[p] = 3'(c);
                @(negedge clk);
                done[p] = 1'b0;
                want = 4'h0;
                want[p] = (p == 1 || p == 3) && (c == 4 || c == 5);
                check({4'h0, sc_req}, {4'h0, want});
            end
        end
        $display("test second_class done");
        event_pulse(1'b0);
        check(pins, 8'h01);
        wr(8'h0e, 8'h00);
        @(negedge clk);
        check(pins, 8'h00);
        wr(8'h0e, 8'h01);
        @(negedge clk);
        check(pins, 8'h01);
        wr(8'h0e, 8'h05);
        check({7'h0, ev_clr}, 8'h00);
        @(negedge clk);
        check(pins, 8'h00);
        rd_chk(8'h0e, 8'h01);
        wr(8'h0e, 8'h00);
        event_pulse(1'b1);
        check(pins, 8'h00);
        wr(8'h0e, 8'h01);
        @(negedge clk);
        check(pins, 8'h02);
        wr(8'h0e, 8'h03);
        check({7'h0, ev_clr}, 8'h01);
        @(negedge clk);
        check(pins, 8'h00);
        rd_chk(8'h0e, 8'h01);
        $display("test interrupts done");
        shed_case(8'he4, 4'hf, 1'b1, 4'h8);
        shed_case(8'he4, 4'h7, 1'b1, 4'h4);
        shed_case(8'h1b, 4'hf, 1'b1, 4'h1);
        shed_case(8'h00, 4'hf, 1'b1, 4'h8);
        shed_case(8'h00, 4'h3, 1'b1, 4'h2);
        shed_case(8'h1b, 4'h0, 1'b1, 4'h0);
        shed_case(8'h1b, 4'hf, 1'b0, 4'h0);
        $display("test shedding done");
        // Move every reset-valued field away so the reset must restore it.
        wr(8'h0b, 8'h00);
        wr(8'h0e, 8'h00);
        do_reset(1'b0, 1'b1);
        rd_chk(8'h0c, 8'h0f);
        rd_chk(8'h0d, 8'he4);
        rd_chk(8'h0b, 8'h01);
        rd_chk(8'h0e, 8'h01);
        $display("test second_reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
